// *** verilog/typeb_pkg.sv ***
package typeb_pkg;
   localparam logic [7:0] CMD_POLL      = 8'h05;
   localparam logic [7:0] CMD_ATTRIB    = 8'h1d;
   localparam logic [7:0] CMD_HLTB      = 8'h50;
   localparam logic [3:0] SLOT_LOW      = 4'h5;
   localparam logic [7:0] ATQB_HEAD     = 8'h50;
   localparam logic [7:0] ATQB_PROTO1   = 8'h00;
   localparam logic [7:0] ATQB_PROTO3   = 8'h51;
   localparam logic [3:0] ATQB_LAST     = 4'hb;
   localparam logic [3:0] ATQB_APP_END  = 4'h8;
   localparam logic [3:0] ATQB_PROTO1_I = 4'h9;
   localparam logic [3:0] ATQB_PROTO2_I = 4'ha;
   localparam logic [7:0] PROTO2_ADDR   = 8'h08;
   localparam logic [3:0] POLL_LEN      = 4'h3;
   localparam logic [3:0] HLTB_LEN      = 4'h5;
   localparam logic [3:0] ATTRIB_LEN    = 4'h9;
   localparam int         PARAM_WAKE    = 3;
   localparam int         ATTRIB_CID_I  = 8;
   localparam int         RX_MAX        = 9;
   localparam int         MEM_DEPTH     = 256;
   localparam logic [15:0] LFSR_SEED    = 16'hace1;
   localparam logic [15:0] LFSR_TAPS    = 16'hb400;
   typedef enum logic [1:0] {ST_IDLE, ST_READY, ST_ACTIVE, ST_HALT} card_state_e;
endpackage

// *** verilog/sysmem_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface sysmem_if;
   logic       wr_en;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_addr;
   logic [7:0] rd_data;
   modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

// *** verilog/sysmem.sv ***
`timescale 1ns/1ns
`default_nettype none
module sysmem #(
   parameter int DEPTH = typeb_pkg::MEM_DEPTH
) (
   input  wire logic clk_i,
   sysmem_if.mem     bus
);
   logic [7:0] mem_q [DEPTH];
   logic [7:0] rd_q;
   assign bus.rd_data = rd_q;
   always_ff @(posedge clk_i) begin
      if (bus.wr_en) begin
         mem_q[bus.wr_addr] <= bus.wr_data;
      end
      rd_q <= mem_q[bus.rd_addr];
   end
endmodule
`default_nettype wire

// *** verilog/typeb_anticollision_decoder.sv ***
`timescale 1ns/1ns
`default_nettype none
module typeb_anticollision_decoder #(
   parameter int         LOCK_LIMIT = 128
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       link_clk_i,
   input  wire logic       rx_valid_i,
   input  wire logic [7:0] rx_byte_i,
   input  wire logic       rx_end_i,
   input  wire logic       rx_crc_ok_i,
   input  wire logic [7:0] stored_afi_i,
   input  wire logic       fuse_set_i,
   input  wire logic       sys_wr_i,
   input  wire logic       sys_rd_i,
   input  wire logic [7:0] sys_addr_i,
   input  wire logic [7:0] sys_wdata_i,
   output logic [7:0]      sys_rdata_o,
   output logic            sys_rvalid_o,
   output logic [7:0]      tx_byte_o,
   output logic            tx_valid_o,
   output logic            tx_last_o,
   output logic [1:0]      card_state_o,
   output logic [3:0]      cid_o,
   output logic            active_cmd_o,
   output logic [3:0]      active_func_o,
   output logic            unsupported_o
);
   localparam int SYNC_W = 12;

   function automatic logic afi_match(input logic [7:0] rx, input logic [7:0] own);
      if (rx == 8'h00) return 1'b1;
      if (rx[3:0] == 4'h0) return rx[7:4] == own[7:4];
      return rx == own;
   endfunction

   function automatic logic func_ok(input logic [3:0] f);
      unique case (f)
         4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   // two stages for every link-side input before anything looks at it
   logic [SYNC_W-1:0] s1_q, s2_q;
   logic              lclk_prev_q;
   always_ff @(posedge clk_i) begin
      s1_q        <= {link_clk_i, rx_valid_i, rx_end_i, rx_crc_ok_i, rx_byte_i};
      s2_q        <= s1_q;
      lclk_prev_q <= s2_q[11];
   end
   logic       edge_w, rxv_w, rxe_w, crc_w;
   logic [7:0] rxb_w;
   assign edge_w = s2_q[11] & ~lclk_prev_q;
   assign rxv_w  = s2_q[10];
   assign rxe_w  = s2_q[9];
   assign crc_w  = s2_q[8];
   assign rxb_w  = s2_q[7:0];

   sysmem_if mbus ();
   sysmem #(.DEPTH(typeb_pkg::MEM_DEPTH)) u_mem (.clk_i(clk_i), .bus(mbus));

   typeb_pkg::card_state_e st_q, st_d;
   logic [7:0]  buf_q [typeb_pkg::RX_MAX];
   logic [7:0]  buf_d [typeb_pkg::RX_MAX];
   logic [3:0]  cnt_q, cnt_d, idx_q, idx_d, cid_q, cid_d, slot_q, slot_d;
   logic [3:0]  func_q, func_d;
   logic        answered_q, answered_d, tx_busy_q, tx_busy_d;
   logic [31:0] pupi_q, pupi_d;
   logic [15:0] lfsr_q, lfsr_d;
   logic [7:0]  txb_q, txb_d;
   logic        txv_q, txv_d, txl_q, txl_d, act_q, act_d, uns_q, uns_d;
   logic        rdv_q, rdv_d, rdpend_q, rdpend_d;
   logic [7:0]  rdata_q, rdata_d;

   always_comb begin
      logic [3:0] nslots;
      logic [3:0] pick;
      logic [7:0] p;
      nslots     = 4'h0;
      pick       = 4'h0;
      p          = buf_q[2];
      st_d       = st_q;
      buf_d      = buf_q;
      cnt_d      = cnt_q;
      idx_d      = idx_q;
      cid_d      = cid_q;
      slot_d     = slot_q;
      func_d     = func_q;
      answered_d = answered_q;
      tx_busy_d  = tx_busy_q;
      pupi_d     = pupi_q;
      txb_d      = txb_q;
      txv_d      = 1'b0;
      txl_d      = 1'b0;
      act_d      = 1'b0;
      uns_d      = 1'b0;
      lfsr_d     = {lfsr_q[14:0], ^(lfsr_q & typeb_pkg::LFSR_TAPS)};
      // system-zone access: writes below LOCK_LIMIT are locked once fuses are blown; reads and higher addresses stay open
      mbus.wr_en   = sys_wr_i & ~(fuse_set_i & (int'(sys_addr_i) < LOCK_LIMIT));
      mbus.wr_addr = sys_addr_i;
      mbus.wr_data = sys_wdata_i;
      mbus.rd_addr = sys_addr_i;
      rdv_d        = 1'b0;
      rdpend_d     = sys_rd_i & ~tx_busy_q;
      rdata_d      = rdata_q;
      if (rdpend_q) begin
         rdata_d = mbus.rd_data;
         rdv_d   = 1'b1;
      end
      if (tx_busy_q) begin
         rdpend_d     = 1'b0;
         // the answer owns the read port; a host read during it is dropped
         mbus.rd_addr = (idx_q == typeb_pkg::ATQB_PROTO2_I) ? typeb_pkg::PROTO2_ADDR
                                                            : {4'h0, idx_q - 4'h1};
      end
      if (edge_w && tx_busy_q) begin
         // half duplex: one byte per link clock, crc appended by the framer on last
         txv_d = 1'b1;
         if (idx_q == 4'h0) begin
            txb_d = typeb_pkg::ATQB_HEAD;
         end else if (idx_q <= typeb_pkg::ATQB_APP_END) begin
            txb_d = mbus.rd_data;
            if (idx_q <= 4'h4) begin
               pupi_d = {pupi_q[23:0], mbus.rd_data};
            end
         end else if (idx_q == typeb_pkg::ATQB_PROTO1_I) begin
            txb_d = typeb_pkg::ATQB_PROTO1;
         end else if (idx_q == typeb_pkg::ATQB_PROTO2_I) begin
            txb_d = mbus.rd_data;
         end else begin
            txb_d = typeb_pkg::ATQB_PROTO3;
         end
         if (idx_q == typeb_pkg::ATQB_LAST) begin
            txl_d     = 1'b1;
            tx_busy_d = 1'b0;
         end
         idx_d = idx_q + 4'h1;
      end else if (edge_w && rxv_w) begin
         if (int'(cnt_q) < typeb_pkg::RX_MAX) begin
            buf_d[cnt_q] = rxb_w;
            cnt_d        = cnt_q + 4'h1;
         end
      end else if (edge_w && rxe_w) begin
         cnt_d = 4'h0;
         if (crc_w && cnt_q != 4'h0) begin
            if (buf_q[0] == typeb_pkg::CMD_POLL) begin
               unique case (p[2:0])
                  3'd0: nslots = 4'd0;
                  3'd1: nslots = 4'd1;
                  3'd2: nslots = 4'd3;
                  3'd3: nslots = 4'd7;
                  3'd4: nslots = 4'd15;
                  default: nslots = 4'd0;
               endcase
               pick = lfsr_q[3:0] & nslots;
               if (cnt_q == typeb_pkg::POLL_LEN && p[7:4] == 4'h0 && p[2:0] <= 3'd4
                   && st_q != typeb_pkg::ST_ACTIVE
                   && (st_q != typeb_pkg::ST_HALT || p[typeb_pkg::PARAM_WAKE])
                   && afi_match(buf_q[1], stored_afi_i)) begin
                  st_d       = typeb_pkg::ST_READY;
                  slot_d     = pick;
                  answered_d = (pick == 4'h0);
                  if (pick == 4'h0) begin
                     tx_busy_d = 1'b1;
                     idx_d     = 4'h0;
                  end
               end
            end else if (buf_q[0][3:0] == typeb_pkg::SLOT_LOW && buf_q[0][7:4] != 4'h0) begin
               // marker s encodes slot s+1; chosen slot k is held as k-1
               if (st_q == typeb_pkg::ST_READY && !answered_q
                   && buf_q[0][7:4] == slot_q) begin
                  answered_d = 1'b1;
                  tx_busy_d  = 1'b1;
                  idx_d      = 4'h0;
               end
            end else if (buf_q[0] == typeb_pkg::CMD_ATTRIB) begin
               if (cnt_q == typeb_pkg::ATTRIB_LEN && st_q == typeb_pkg::ST_READY && answered_q
                   && {buf_q[1], buf_q[2], buf_q[3], buf_q[4]} == pupi_q) begin
                  st_d  = typeb_pkg::ST_ACTIVE;
                  cid_d = buf_q[typeb_pkg::ATTRIB_CID_I][7:4];
               end
            end else if (buf_q[0] == typeb_pkg::CMD_HLTB) begin
               if (cnt_q == typeb_pkg::HLTB_LEN && st_q == typeb_pkg::ST_READY && answered_q
                   && {buf_q[1], buf_q[2], buf_q[3], buf_q[4]} == pupi_q) begin
                  st_d = typeb_pkg::ST_HALT;
               end
            end else if (st_q == typeb_pkg::ST_ACTIVE && buf_q[0][7:4] == cid_q) begin
               if (func_ok(buf_q[0][3:0])) begin
                  act_d  = 1'b1;
                  func_d = buf_q[0][3:0];
               end else begin
                  uns_d = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q       <= typeb_pkg::ST_IDLE;
         for (int i = 0; i < typeb_pkg::RX_MAX; i++) begin
            buf_q[i] <= 8'h00;
         end
         cnt_q      <= 4'h0;
         idx_q      <= 4'h0;
         cid_q      <= 4'h0;
         slot_q     <= 4'h0;
         func_q     <= 4'h0;
         answered_q <= 1'b0;
         tx_busy_q  <= 1'b0;
         pupi_q     <= 32'h0000_0000;
         lfsr_q     <= typeb_pkg::LFSR_SEED;
         txb_q      <= 8'h00;
         txv_q      <= 1'b0;
         txl_q      <= 1'b0;
         act_q      <= 1'b0;
         uns_q      <= 1'b0;
         rdv_q      <= 1'b0;
         rdpend_q   <= 1'b0;
         rdata_q    <= 8'h00;
      end else begin
         st_q       <= st_d;
         buf_q      <= buf_d;
         cnt_q      <= cnt_d;
         idx_q      <= idx_d;
         cid_q      <= cid_d;
         slot_q     <= slot_d;
         func_q     <= func_d;
         answered_q <= answered_d;
         tx_busy_q  <= tx_busy_d;
         pupi_q     <= pupi_d;
         lfsr_q     <= lfsr_d;
         txb_q      <= txb_d;
         txv_q      <= txv_d;
         txl_q      <= txl_d;
         act_q      <= act_d;
         uns_q      <= uns_d;
         rdv_q      <= rdv_d;
         rdpend_q   <= rdpend_d;
         rdata_q    <= rdata_d;
      end
   end

   assign tx_byte_o     = txb_q;
   assign tx_valid_o    = txv_q;
   assign tx_last_o     = txl_q;
   assign card_state_o  = st_q;
   assign cid_o         = cid_q;
   assign active_cmd_o  = act_q;
   assign active_func_o = func_q;
   assign unsupported_o = uns_q;
   assign sys_rdata_o   = rdata_q;
   assign sys_rvalid_o  = rdv_q;
endmodule
`default_nettype wire

// *** sim/reader_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module reader_model (
   input  wire logic       clk_i,
   output logic            link_clk_o,
   output logic            rx_valid_o,
   output logic [7:0]      rx_byte_o,
   output logic            rx_end_o,
   output logic            rx_crc_ok_o
);
   initial begin
      link_clk_o = 1'b0;
      rx_valid_o = 1'b0;
      rx_byte_o = 8'h00;
      rx_end_o = 1'b0;
      rx_crc_ok_o = 1'b0;
   end
   // lines move only while the link clock is low, so its rising edge sees them settled
   task automatic tick(input logic v, input logic [7:0] b, input logic e, input logic ok);
      rx_valid_o = v;
      rx_byte_o = b;
      rx_end_o = e;
      rx_crc_ok_o = ok;
      repeat (4) @(negedge clk_i);
      link_clk_o = 1'b1;
      repeat (4) @(negedge clk_i);
      link_clk_o = 1'b0;
   endtask
   // released data lines toggle so a stale byte never looks valid
   task automatic send(input logic [7:0] f[$], input logic ok);
      foreach (f[i]) tick(1'b1, f[i], 1'b0, 1'b0);
      tick(1'b0, ~f[f.size()-1], 1'b1, ok);
      repeat (16) tick(1'b0, ~rx_byte_o, 1'b0, ~rx_crc_ok_o);
   endtask
endmodule
`default_nettype wire

// *** sim/typeb_anticollision_decoder_sva.sv ***
`timescale 1ns/1ns
`default_nettype none
module typeb_anticollision_decoder_sva (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       sys_rd_i,
   input  wire logic [7:0] sys_rdata_o,
   input  wire logic       sys_rvalid_o,
   input  wire logic [7:0] tx_byte_o,
   input  wire logic       tx_valid_o,
   input  wire logic       tx_last_o,
   input  wire logic [1:0] card_state_o,
   input  wire logic [3:0] cid_o,
   input  wire logic       active_cmd_o,
   input  wire logic       unsupported_o
);
   logic [3:0] idx_q;
   logic [3:0] idx_d;
   always_comb begin
      idx_d = idx_q;
      if (tx_last_o) idx_d = 4'h0;
      else if (tx_valid_o) idx_d = idx_q + 4'h1;
   end
   always_ff @(posedge clk_i) begin
      idx_q <= rst_i ? 4'h0 : idx_d;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_head_first: assert property (tx_valid_o && idx_q == 4'h0 |-> tx_byte_o == 8'h50)
      else $error("answer does not open with head byte");
   a_proto_zero: assert property (tx_valid_o && idx_q == 4'h9 |-> tx_byte_o == 8'h00)
      else $error("first protocol byte wrong");
   a_last_place: assert property (tx_last_o |-> tx_valid_o && idx_q == 4'hb && tx_byte_o == 8'h51)
      else $error("answer end misplaced");
   a_byte_spacing: assert property (tx_valid_o |=> (!tx_valid_o) [*3])
      else $error("answer bytes too close");
   a_rd_latency: assert property (sys_rvalid_o |-> $past(sys_rd_i, 2))
      else $error("read valid without read");
   a_rdata_hold: assert property ($changed(sys_rdata_o) |-> sys_rvalid_o)
      else $error("read data moved without valid");
   a_pulse_excl: assert property (!(active_cmd_o && unsupported_o))
      else $error("command both defined and unsupported");
   a_cmd_active: assert property (active_cmd_o || unsupported_o |-> card_state_o == 2'd2)
      else $error("active command outside active state");
   a_halt_exit: assert property (card_state_o == 2'd3 |=> card_state_o inside {2'd3, 2'd1})
      else $error("halt left other than to ready");
   a_cid_active: assert property ($changed(cid_o) |-> card_state_o == 2'd2)
      else $error("card id changed outside activation");
   c_answer: cover property (tx_last_o);
   c_active: cover property (active_cmd_o);
   c_unsup: cover property (unsupported_o);
   c_halt: cover property (card_state_o == 2'd3);
endmodule
bind typeb_anticollision_decoder typeb_anticollision_decoder_sva sva_inst (.*);
`default_nettype wire

// *** sim/tb_typeb_anticollision_decoder.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_typeb_anticollision_decoder;
   logic       clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic       link_clk, rx_valid, rx_end, rx_crc_ok, sys_rvalid, tx_valid, tx_last, act, uns;
   logic [7:0] rx_byte, sys_rdata, tx_byte;
   logic [7:0] afi = 8'h34;
   logic       fuse = 1'b0;
   logic       sys_wr = 1'b0;
   logic       sys_rd = 1'b0;
   logic [7:0] sys_addr = 8'h00;
   logic [7:0] sys_wdata = 8'h00;
   logic [1:0] state;
   logic [3:0] cid, func;
   logic [8:0] got[$];
   logic [8:0] atqb[12];
   logic [7:0] m[9];
   int         error_cnt = 0;
   int         tests_run = 0;
   int         act_n = 0;
   int         uns_n = 0;
   int         ans;
   // afi, param, crc verdict, answer expected
   localparam logic [17:0] ROWS[11] = '{{16'h0000, 2'b11}, {16'h3000, 2'b11}, {16'h3400, 2'b11},
      {16'h3500, 2'b10}, {16'h4000, 2'b10}, {16'h0000, 2'b00}, {16'h0010, 2'b10},
      {16'h0005, 2'b10}, {16'h0007, 2'b10}, {16'h0008, 2'b11}, {16'h0400, 2'b10}};
   localparam logic [3:0] FUNCS[15] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'h9, 4'hc,
      4'h0, 4'h7, 4'hd, 4'he, 4'hf, 4'ha, 4'hb};
   always #20 clk_i = ~clk_i;
   reader_model reader_model_inst (.clk_i(clk_i), .link_clk_o(link_clk), .rx_valid_o(rx_valid),
      .rx_byte_o(rx_byte), .rx_end_o(rx_end), .rx_crc_ok_o(rx_crc_ok));
   typeb_anticollision_decoder typeb_anticollision_decoder_inst (
      .clk_i(clk_i), .rst_i(rst_i), .link_clk_i(link_clk), .rx_valid_i(rx_valid),
      .rx_byte_i(rx_byte), .rx_end_i(rx_end), .rx_crc_ok_i(rx_crc_ok), .stored_afi_i(afi),
      .fuse_set_i(fuse), .sys_wr_i(sys_wr), .sys_rd_i(sys_rd), .sys_addr_i(sys_addr),
      .sys_wdata_i(sys_wdata), .sys_rdata_o(sys_rdata), .sys_rvalid_o(sys_rvalid),
      .tx_byte_o(tx_byte), .tx_valid_o(tx_valid), .tx_last_o(tx_last), .card_state_o(state),
      .cid_o(cid), .active_cmd_o(act), .active_func_o(func), .unsupported_o(uns));
   always @(negedge clk_i) begin
      if (tx_valid) got.push_back({tx_last, tx_byte});
      if (act) act_n++;
      if (uns) uns_n++;
   end
   task automatic chk(input logic [8:0] g, input logic [8:0] e);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic print_verdict;
      if (error_cnt == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // exp: 1 full answer, 0 silence, 2 only count answers
   task automatic frame(input logic [7:0] f[$], input logic ok, input int exp);
      got.delete();
      reader_model_inst.send(f, ok);
      ans = 0;
      foreach (got[i]) ans += got[i][8];
      if (exp == 1) foreach (atqb[i]) chk(got[i], atqb[i]);
      if (exp != 2) chk(9'(got.size()), exp ? 9'd12 : 9'd0);
   endtask
   task automatic do_reset;
      rst_i = 1'b1;
      repeat (6) @(negedge clk_i);
      rst_i = 1'b0;
      repeat (3) @(negedge clk_i);
      chk({1'b0, tx_valid, state, cid, act}, 9'h0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sys_wr = 1'b1;
      sys_addr = a;
      sys_wdata = d;
      @(negedge clk_i);
      sys_wr = 1'b0;
      @(negedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      sys_rd = 1'b1;
      sys_addr = a;
      @(negedge clk_i);
      sys_rd = 1'b0;
      repeat (3) begin
         @(negedge clk_i);
         if (sys_rvalid) break;
      end
      chk({sys_rvalid, sys_rdata}, {1'b1, e});
   endtask
   initial begin
      int n, a0, u0;
      logic [3:0] lf;
      logic def;
      do_reset;
      foreach (m[i]) begin
         m[i] = 8'ha0 + 8'(i);
         wr(8'(i), m[i]);
      end
      atqb[0] = 9'h050;
      for (int i = 0; i < 8; i++) atqb[i+1] = {1'b0, m[i]};
      atqb[9] = 9'h000;
      atqb[10] = {1'b0, m[8]};
      atqb[11] = 9'h151;
      rd(8'h03, m[3]);
      foreach (ROWS[r]) begin
         do_reset;
         frame('{8'h05, ROWS[r][17:10], ROWS[r][9:2]}, ROWS[r][1], int'(ROWS[r][0]));
         chk({7'h0, state}, {8'h0, ROWS[r][0]});
      end
      do_reset;
      frame('{8'h05, 8'h00, 8'h04}, 1'b1, 2);
      n = ans;
      for (int s = 1; s < 16; s++) frame('{{s[3:0], 4'h5}}, 1'b0, 0);
      for (int s = 1; s < 16; s++) begin
         frame('{{s[3:0], 4'h5}}, 1'b1, 2);
         n += ans;
      end
      chk(9'(n), 9'd1);
      do_reset;
      frame('{8'h05, 8'h00, 8'h00}, 1'b1, 1);
      frame('{8'h50, m[0], m[1], m[2], m[3]}, 1'b1, 2);
      chk({7'h0, state}, 9'h3);
      frame('{8'h05, 8'h00, 8'h00}, 1'b1, 0);
      frame('{8'h05, 8'h00, 8'h08}, 1'b1, 1);
      // the card id rides in the upper nibble of the last attach-select byte
      frame('{8'h1d, m[0], m[1], m[2], m[3], 8'h00, 8'h00, 8'h00, 8'h70}, 1'b1, 2);
      chk({3'h0, state, cid}, {3'h0, 2'd2, 4'h7});
      frame('{8'h05, 8'h00, 8'h00}, 1'b1, 0);
      frame('{8'h15}, 1'b1, 0);
      lf = 4'h0;
      foreach (FUNCS[k]) begin
         a0 = act_n;
         u0 = uns_n;
         def = (k < 8) || (k > 12);
         frame('{{4'h7, FUNCS[k]}}, 1'b1, 2);
         if (def) lf = FUNCS[k];
         chk({1'b0, func, 2'(act_n - a0), 2'(uns_n - u0)}, {1'b0, lf, 1'b0, def, 1'b0, !def});
      end
      fuse = 1'b1;
      wr(8'h00, 8'h5a);
      wr(8'h90, 8'h5a);
      rd(8'h00, m[0]);
      rd(8'h90, 8'h5a);
      print_verdict;
   end
endmodule
`default_nettype wire
